/* common/bsc_pkg.sv */
// Constants and types for the bus controller register bank and decoder
`default_nettype none
package bsc_pkg;
   // Register bank layout
   localparam int NREG = 10;
   localparam logic [31:0] REG_OFS [NREG] = '{
      32'h0FFFFFC0, // wait_control_two
      32'h0FFFFFC4, // wait_control_three
      32'h0FFFFFE8, // wait_control_one
      32'h0FFFFFF0, // refresh_timer_ctrl_status
      32'h0FFFFFF4, // refresh_timer_count
      32'h0FFFFFF8, // refresh_time_constant
      32'h0FFFFFFC, // bus_control_three
      32'hFFFFFFE0, // bus_control_one
      32'hFFFFFFEC, // memory_interface_control
      32'hFFFFFFF4  // bus_control_two
   };
   localparam logic [15:0] REG_RST [NREG] = '{
      16'h000B, 16'h0000, 16'hAAFF, 16'h0000, 16'h0000,
      16'h0000, 16'h0F00, 16'h03F0, 16'h0000, 16'h00FC
   };
   localparam logic [3:0] IDX_BUS_CONTROL_ONE = 4'h7;
   localparam logic [31:0] STATUS_OFS = 32'hFFFFFFD0;
   localparam logic [31:0] HALF_OFS = 32'h00000002;
   localparam logic [15:0] WR_KEY = 16'hA55A;
   localparam logic [15:0] UPPER_ZERO = 16'h0000;
   // Fields of bus_control_one
   localparam int BC1_BURST_ROM_BIT = 11;
   localparam int BC1_DRAM_LSB = 0;
   localparam logic [2:0] DRAM_CS3_SDRAM = 3'h1;
   localparam logic [2:0] DRAM_CS3_DRAM = 3'h2;
   localparam logic [2:0] DRAM_CS2_SDRAM = 3'h4;
   localparam logic [2:0] DRAM_BOTH_SDRAM = 3'h5;
   // Address map
   localparam int NUM_AREAS = 5;
   localparam int AREA_LOG2 = 25;
   localparam int ALIAS_BIT = 29;
   localparam logic [31:0] XRAM_BASE = 32'h1000E000;
   localparam logic [31:0] YRAM_BASE = 32'h1001E000;
   localparam int RAM_WIN_LOG2 = 13;
   // Bus masters
   typedef enum logic [1:0] {
      MST_CPU = 2'h0,
      MST_DMA = 2'h1,
      MST_ETH_DMA = 2'h2,
      MST_OTHER = 2'h3
   } bsc_master_e;
   // Memory kind of a decoded access
   typedef enum logic [2:0] {
      KIND_NONE = 3'h0,
      KIND_ORD = 3'h1,
      KIND_BROM = 3'h2,
      KIND_SDRAM = 3'h3,
      KIND_DRAM = 3'h4,
      KIND_ONCHIP = 3'h5
   } bsc_kind_e;
   // One access from an internal master
   typedef struct packed {
      logic [31:0] addr;
      logic wr;
      logic [3:0] be;
      bsc_master_e master;
   } bsc_req_s;
endpackage
`default_nettype wire

/* dv/bsc_ext_dev.sv */
// External device model that can float the bus
`default_nettype none
module bsc_ext_dev (
   input wire logic i_core_clk,
   input wire logic i_float_cmd,
   output var logic o_bus_float_request = 1'b0,
   output var logic o_wait_n = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // Wait goes low first; float only ever rides on wait
   always @(posedge i_core_clk) begin
      o_wait_n <= !i_float_cmd;
      o_bus_float_request <= i_float_cmd && !o_wait_n;
   end
endmodule
`default_nettype wire

/* dv/bsc_regs_decode_chk.sv */
// Assertion checker for the bus controller decode block
`default_nettype none
module bsc_regs_decode_chk
   import bsc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_req_valid,
   input wire bsc_req_s i_req,
   input wire logic i_refresh_due,
   input wire logic i_bus_released,
   input wire logic i_bus_float_request,
   input wire logic i_wait_n,
   input wire logic [31:0] o_reg_rdata,
   input wire logic [4:0] o_area_select_n,
   input wire logic o_xram_select,
   input wire logic o_yram_select,
   input wire logic [24:0] o_ext_addr,
   input wire logic [2:0] o_mem_kind,
   input wire logic [3:0] o_lane_mask_write_strobe_n,
   input wire logic [3:0] o_lane_column_strobe_n,
   input wire logic [1:0] o_bus_master_id,
   input wire logic o_refresh_request_out,
   input wire logic o_bus_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] calm_r;
   logic take_r;
   bsc_req_s q_r;
   // Float-free run length and the request taken last edge
   always_ff @(posedge i_core_clk) begin
      if (i_srst || i_bus_float_request) calm_r <= 2'h0;
      else if (calm_r != 2'h3) calm_r <= calm_r + 2'h1;
      take_r <= !i_srst && i_req_valid && calm_r == 2'h3;
      q_r <= i_req;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   // Register and refresh outputs
   a_upper_zero: assert property (
      o_reg_rdata[31:16] == 16'h0000) else $error("upper half set");
   a_refresh_req: assert property (
      !$past(i_srst) |-> o_refresh_request_out ==
      ($past(i_refresh_due) && $past(i_bus_released)))
      else $error("bad refresh request");
   // Decode outputs one edge after a taken request
   a_master_id: assert property (
      take_r |-> o_bus_master_id == q_r.master) else $error("bad master");
   a_write_strobe: assert property (
      take_r && o_mem_kind == KIND_ORD |-> o_lane_mask_write_strobe_n ==
      (q_r.wr ? ~q_r.be : 4'hF)) else $error("bad write strobe");
   a_sdram_mask: assert property (
      take_r && o_mem_kind == KIND_SDRAM |->
      o_lane_mask_write_strobe_n == ~q_r.be) else $error("bad mask");
   a_column_strobe: assert property (
      take_r |-> o_lane_column_strobe_n ==
      (o_mem_kind == KIND_DRAM ? ~q_r.be : 4'hF)) else $error("bad column");
   a_dram_no_cs: assert property (
      o_mem_kind == KIND_DRAM |-> o_area_select_n == 5'h1F)
      else $error("select in dram");
   a_area_select: assert property (
      take_r && q_r.addr[31:30] == 2'h0 && q_r.addr[28:25] < 4'h5 &&
      o_mem_kind != KIND_DRAM |-> o_area_select_n ==
      ~(5'h01 << q_r.addr[27:25]) && o_ext_addr == q_r.addr[24:0])
      else $error("bad area decode");
   a_reserved: assert property (
      take_r && (q_r.addr[31:30] != 2'h0 || q_r.addr[28:25] > 4'h4) |->
      o_area_select_n == 5'h1F) else $error("select in reserved");
   a_ram_window: assert property (
      take_r |-> o_xram_select == (q_r.addr[31:13] == XRAM_BASE[31:13]) &&
      o_yram_select == (q_r.addr[31:13] == YRAM_BASE[31:13]))
      else $error("bad ram window");
   // Float with wait releases the pins and holds the cycle
   a_float_oe: assert property (
      (i_bus_float_request && !i_wait_n) [*3] |-> ##[0:1] !o_bus_oe)
      else $error("pins not floated");
   a_float_hold: assert property (
      !o_bus_oe |-> $stable(o_area_select_n) && $stable(o_bus_master_id))
      else $error("cycle not held");
endmodule
bind bsc_regs_decode bsc_regs_decode_chk i_chk (.*);
`default_nettype wire

/* dv/bsc_regs_decode_test.sv */
// Self-checking bench for the bus controller decode block
`default_nettype none
module bsc_regs_decode_test
   import bsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] TA [8] = '{32'h00000010, 32'h22000020,
      32'h04000030, 32'h26000040, 32'h08000050, 32'h0A000000,
      32'h1000E010, 32'h1001E020};
   localparam bsc_kind_e TK [8] = '{KIND_ORD, KIND_ORD, KIND_ORD,
      KIND_ORD, KIND_ORD, KIND_NONE, KIND_ONCHIP, KIND_ONCHIP};
   localparam logic [15:0] KB [4] = '{16'h0002, 16'h0001, 16'h0004, 16'h0800};
   localparam logic [31:0] KA [4] = '{32'h06000000, 32'h06000000,
      32'h04000000, 32'h00000000};
   localparam bsc_kind_e KK [4] = '{KIND_DRAM, KIND_SDRAM, KIND_SDRAM,
      KIND_BROM};
   logic i_core_clk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_reg_size32 = 1'b0, i_req_valid = 1'b0, i_refresh_due = 1'b0;
   logic i_bus_released = 1'b0, fcmd = 1'b0;
   logic [31:0] i_reg_addr = '0, i_reg_wdata = '0, o_reg_rdata;
   bsc_req_s i_req = '0;
   logic i_bus_float_request, i_wait_n, o_access_valid, o_xram_select;
   logic o_yram_select, o_refresh_request_out, o_bus_oe;
   logic [4:0] o_area_select_n;
   logic [24:0] o_ext_addr;
   logic [2:0] o_mem_kind;
   logic [3:0] o_lane_mask_write_strobe_n, o_lane_column_strobe_n;
   logic [1:0] o_bus_master_id;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   bsc_regs_decode i_bsc_regs_decode (.*);
   bsc_ext_dev i_bsc_ext_dev (.i_core_clk(i_core_clk), .i_float_cmd(fcmd),
      .o_bus_float_request(i_bus_float_request), .o_wait_n(i_wait_n));
   // Clock and hang guard
   initial forever #10 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end
   // Expected chip selects of an address
   function automatic logic [4:0] esel(input logic [31:0] a);
      if (a[31:30] != 2'h0 || a[28:25] > 4'h4) return 5'h1F;
      return ~(5'h01 << a[27:25]);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, d, input logic s32);
      @(posedge i_core_clk);
      {i_reg_addr, i_reg_wdata, i_reg_size32, i_reg_wr} <= {a, d, s32, 1'b1};
      @(posedge i_core_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic s32,
      input logic [31:0] e);
      @(posedge i_core_clk);
      {i_reg_addr, i_reg_size32, i_reg_rd} <= {a, s32, 1'b1};
      @(posedge i_core_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_core_clk);
      chk(o_reg_rdata, e);
   endtask
   task automatic acc(input logic [31:0] a, input logic w, input logic [3:0] b,
      input logic [1:0] m);
      @(posedge i_core_clk);
      i_req_valid <= 1'b1;
      i_req <= '{addr: a, wr: w, be: b, master: bsc_master_e'(m)};
      @(posedge i_core_clk);
      i_req_valid <= 1'b0;
      @(negedge i_core_clk);
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Test sequence
   initial begin
      repeat (10) @(posedge i_core_clk);
      i_srst <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
         rd(REG_OFS[i], 1'b1, {16'h0000, REG_RST[i]});
         rd(REG_OFS[i] + HALF_OFS, 1'b0, {16'h0000, REG_RST[i]});
         wr(REG_OFS[i], {16'h5AA5, ~REG_RST[i]}, 1'b1);
         wr(REG_OFS[i] + HALF_OFS, {WR_KEY, ~REG_RST[i]}, 1'b0);
         rd(REG_OFS[i], 1'b1, {16'h0000, REG_RST[i]});
         wr(REG_OFS[i], {WR_KEY, REG_RST[i] ^ 16'h0300}, 1'b1);
         rd(REG_OFS[i], 1'b1, {16'h0000, REG_RST[i] ^ 16'h0300});
      end
      rd(REG_OFS[0] + HALF_OFS, 1'b1, 32'h0);
      rd(32'h0FFFFFC8, 1'b1, 32'h0);
      rd(STATUS_OFS, 1'b1, 32'h00000400);
      rd(STATUS_OFS, 1'b1, 32'h0);
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         acc(TA[i], i[0], 4'(i + 3), i[1:0]);
         chk(32'(o_area_select_n), 32'(esel(TA[i])));
         chk(32'(o_mem_kind), 32'(TK[i]));
         chk(32'({o_xram_select, o_yram_select}), 32'({i == 6, i == 7}));
         chk(32'(o_bus_master_id), 32'(i[1:0]));
         chk(32'(o_lane_mask_write_strobe_n),
            (i[0] && i < 5) ? {28'h0, ~4'(i + 3)} : 32'hF);
         if (i < 5) chk(32'(o_ext_addr), 32'(TA[i][24:0]));
      end
      @(negedge i_core_clk);
      chk(32'({o_access_valid, o_area_select_n}), 32'h1F);
      $display("decode test done");
      for (int i = 0; i < 4; i++) begin
         wr(REG_OFS[IDX_BUS_CONTROL_ONE], {WR_KEY, KB[i]}, 1'b1);
         acc(KA[i], 1'b0, 4'h6, 2'h1);
         chk(32'(o_mem_kind), 32'(KK[i]));
         chk(32'(o_area_select_n), i == 0 ? 32'h1F : 32'(esel(KA[i])));
         chk(32'(o_lane_column_strobe_n), i == 0 ? 32'h9 : 32'hF);
         chk(32'(o_lane_mask_write_strobe_n), i % 3 ? 32'h9 : 32'hF);
      end
      $display("kind test done");
      for (int k = 0; k < 4; k++) begin
         @(posedge i_core_clk);
         {i_bus_released, i_refresh_due} <= 2'(k);
         @(posedge i_core_clk);
         @(negedge i_core_clk);
         chk(32'(o_refresh_request_out), 32'(k == 3));
      end
      $display("refresh test done");
      @(posedge i_core_clk);
      fcmd <= 1'b1;
      repeat (7) @(negedge i_core_clk);
      chk(32'(o_bus_oe), 32'h0);
      acc(32'h02000000, 1'b1, 4'hF, 2'h2);
      chk(32'({o_access_valid, o_area_select_n, o_bus_master_id}), 32'h7D);
      @(posedge i_core_clk);
      fcmd <= 1'b0;
      repeat (7) @(negedge i_core_clk);
      chk(32'(o_bus_oe), 32'h1);
      acc(32'h02000000, 1'b1, 4'hF, 2'h2);
      chk(32'(o_area_select_n), 32'h1D);
      $display("float test done");
      print_verdict();
   end
endmodule
`default_nettype wire

/* hw/bsc_regs_decode.sv */
// Bus controller register bank, address decoder and lane strobes
//
// Overview of operation
// R01: Registers are 16 bits, upper read zero
// R02: 32-bit write needs key in upper half
// R03: 16-bit accesses are read only
// R04: 16-bit address is 32-bit address plus two
// R05: Software uses only area 0 until setup
// R06: Software initialises reserved register bits
// R07: Drive two-bit identifier of current master
// R08: Ordinary writes: one strobe per byte lane
// R09: Synchronous DRAM reuses strobes as lane masks
// R10: DRAM gets four per-lane column strobes
// R11: Refresh request out while bus released
// R12: Float input with wait tristates, cycle kept
// R13: Areas 0-4 are consecutive 32 MB windows
// R14: Each area allows only its memory kinds
// R15: Cache-through alias reaches same location
// R16: Only 160 MB externally connectable
// R17: Two 8 KB windows go to on-chip RAM
// R18: Area 3 select idle when area is DRAM
// R19: Reserved ranges assert no chip select
`default_nettype none
module bsc_regs_decode
   import bsc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Register port
   input wire logic [31:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic i_reg_size32,
   output logic [31:0] o_reg_rdata,
   // Access from internal masters
   input wire logic i_req_valid,
   input wire bsc_req_s i_req,
   // Refresh and bus release state
   input wire logic i_refresh_due,
   input wire logic i_bus_released,
   // External pins (asynchronous)
   input wire logic i_bus_float_request,
   input wire logic i_wait_n,
   // Decoded outputs
   output logic o_access_valid,
   output logic [4:0] o_area_select_n,
   output logic o_xram_select,
   output logic o_yram_select,
   output logic [24:0] o_ext_addr,
   output logic [2:0] o_mem_kind,
   output logic [3:0] o_lane_mask_write_strobe_n,
   output logic [3:0] o_lane_column_strobe_n,
   output logic [1:0] o_bus_master_id,
   output logic o_refresh_request_out,
   output logic o_bus_oe
);

   // Register storage
   logic [15:0] regs_r [NREG];
   logic [31:0] rdata_r;
   logic key_fail_r;

   // Decoder state
   logic valid_r;
   logic [4:0] cs_n_r;
   logic xram_r;
   logic yram_r;
   logic [24:0] ext_addr_r;
   bsc_kind_e kind_r;
   logic [3:0] lane_n_r;
   logic [3:0] cas_n_r;
   bsc_master_e master_r;
   logic refresh_request_out_r;
   logic oe_r;

   // Pin synchronisers
   logic float_s1_r;
   logic float_s2_r;
   logic wait_n_s1_r;
   logic wait_n_s2_r;
   logic float_active;

   // Register lookup: bit 4 is hit, bits 3:0 index
   // 16-bit reads sit two bytes up, so the base is rebuilt first
   function automatic logic [4:0] reg_find(
      input logic [31:0] a,
      input logic s32
   );
      logic [4:0] r;
      logic [31:0] eff;
      r = 5'h00;
      eff = s32 ? a : a - HALF_OFS; // R04
      for (int k = 0; k < NREG; k++) begin
         if (eff == REG_OFS[k]) begin
            r = {1'b1, 4'(k)};
         end
      end
      return r;
   endfunction

   // Memory kind of an area under current configuration
   // Reserved DRAM field codes fall back to ordinary space
   function automatic bsc_kind_e area_kind(
      input logic [2:0] area,
      input logic [15:0] bc1
   );
      bsc_kind_e k;
      logic [2:0] dm;
      k = KIND_NONE;
      dm = bc1[BC1_DRAM_LSB +: 3];
      case (area) // R14
         3'h0: begin
            k = bc1[BC1_BURST_ROM_BIT] ? KIND_BROM : KIND_ORD;
         end
         3'h1: begin
            k = KIND_ORD;
         end
         3'h2: begin
            if (dm == DRAM_CS2_SDRAM || dm == DRAM_BOTH_SDRAM) begin
               k = KIND_SDRAM;
            end else begin
               k = KIND_ORD;
            end
         end
         3'h3: begin
            if (dm == DRAM_CS3_SDRAM || dm == DRAM_BOTH_SDRAM) begin
               k = KIND_SDRAM;
            end else if (dm == DRAM_CS3_DRAM) begin
               k = KIND_DRAM;
            end else begin
               k = KIND_ORD;
            end
         end
         3'h4: begin
            k = KIND_ORD;
         end
         default: begin
            k = KIND_NONE;
         end
      endcase
      return k;
   endfunction

   // Register port decode
   // Writes are always looked up at the 32-bit address
   logic [4:0] wr_find;
   logic [4:0] rd_find;
   logic wr_key_ok;
   logic wr_hit;
   logic wr_refused;
   logic status_rd;

   assign wr_find = reg_find(i_reg_addr, 1'b1);
   assign rd_find = reg_find(i_reg_addr, i_reg_size32);
   assign wr_key_ok = (i_reg_wdata[31:16] == WR_KEY);
   assign wr_hit = i_reg_wr & i_reg_size32 & wr_key_ok & wr_find[4]; // R02
   assign wr_refused = i_reg_wr & i_reg_size32 & wr_find[4] & ~wr_key_ok;
   assign status_rd = i_reg_rd & i_reg_size32 & (i_reg_addr == STATUS_OFS);

   // Keyed register write; 16-bit writes never land
   // Only the lower half is stored; the key itself is never kept
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         for (int k = 0; k < NREG; k++) begin
            regs_r[k] <= REG_RST[k];
         end
      end else if (wr_hit) begin // R03
         regs_r[wr_find[3:0]] <= i_reg_wdata[15:0]; // R02
      end
   end

   // Sticky flag for key-refused writes, cleared by status read
   // A refusal in the same cycle as the clearing read stays visible
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         key_fail_r <= 1'b0;
      end else if (wr_refused) begin
         key_fail_r <= 1'b1; // Set wins over clear
      end else if (status_rd) begin
         key_fail_r <= 1'b0;
      end
   end

   // Status word: only a read tells software a keyed write was refused
   logic [15:0] status_w;
   assign status_w = {
      5'h00,
      key_fail_r, // Refused keyed write seen
      ~oe_r, // Bus and strobes floated
      valid_r,
      master_r,
      kind_r,
      cs_n_r[4:3] == 2'h0,
      1'b0,
      xram_r | yram_r // On-chip RAM window hit
   };

   // Read data, one cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         rdata_r <= 32'h00000000;
      end else if (i_reg_rd && rd_find[4]) begin
         rdata_r <= {UPPER_ZERO, regs_r[rd_find[3:0]]}; // R01
      end else if (status_rd) begin
         rdata_r <= {UPPER_ZERO, status_w}; // R01
      end else begin
         rdata_r <= 32'h00000000;
      end
   end

   // Two-stage synchronisers for the float and wait pins
   // Pins are asynchronous; decode only ever reads the second stage
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         float_s1_r <= 1'b0;
         float_s2_r <= 1'b0;
         wait_n_s1_r <= 1'b1;
         wait_n_s2_r <= 1'b1;
      end else begin
         float_s1_r <= i_bus_float_request;
         float_s2_r <= float_s1_r;
         wait_n_s1_r <= i_wait_n;
         wait_n_s2_r <= wait_n_s1_r;
      end
   end

   assign float_active = float_s2_r & ~wait_n_s2_r; // R12

   // Address decode of the incoming access
   logic [31:0] a;
   logic through;
   logic [3:0] area_f;
   logic ext_hit;
   logic x_hit;
   logic y_hit;
   bsc_kind_e kind_d;
   logic [4:0] cs_n_d;
   logic [3:0] lane_n_d;
   logic [3:0] cas_n_d;

   assign a = i_req.addr;
   assign through = a[ALIAS_BIT]; // R15
   assign area_f = a[AREA_LOG2 +: 4];

   // Areas sit in cache and cache-through halves only
   assign ext_hit = (a[31:30] == 2'h0) && (area_f < 4'(NUM_AREAS)); // R13 R19

   // On-chip RAM windows in the cache half only
   assign x_hit = (a[31:RAM_WIN_LOG2] == XRAM_BASE[31:RAM_WIN_LOG2]); // R17
   assign y_hit = (a[31:RAM_WIN_LOG2] == YRAM_BASE[31:RAM_WIN_LOG2]); // R17

   // Kind, chip selects and lane strobes
   // On-chip windows win over the external areas
   always_comb begin
      kind_d = KIND_NONE;
      cs_n_d = 5'h1F;
      lane_n_d = 4'hF;
      cas_n_d = 4'hF;
      if (x_hit || y_hit) begin
         kind_d = KIND_ONCHIP; // R17
      end else if (ext_hit) begin
         kind_d = area_kind(area_f[2:0], regs_r[IDX_BUS_CONTROL_ONE]);
         cs_n_d[area_f[2:0]] = 1'b0; // R13
         if (kind_d == KIND_DRAM) begin
            // DRAM in area 3 runs on row and column strobes only
            cs_n_d[3] = 1'b1; // R18
         end
      end
      case (kind_d)
         KIND_SDRAM: begin
            lane_n_d = ~i_req.be; // R09
         end
         KIND_DRAM: begin
            cas_n_d = ~i_req.be; // R10
         end
         KIND_ORD, KIND_BROM: begin
            if (i_req.wr) begin
               lane_n_d = ~i_req.be; // R08
            end
         end
         default: begin
            lane_n_d = 4'hF;
         end
      endcase
   end

   // Registered decode; held while the bus floats
   // A floated cycle is frozen, not ended: it resumes where it stood
   // once the float drops, so nothing here may change meanwhile
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         valid_r <= 1'b0;
         cs_n_r <= 5'h1F;
         xram_r <= 1'b0;
         yram_r <= 1'b0;
         ext_addr_r <= 25'h0000000;
         kind_r <= KIND_NONE;
         lane_n_r <= 4'hF;
         cas_n_r <= 4'hF;
      end else if (float_active) begin
         valid_r <= valid_r; // R12
      end else if (i_req_valid) begin
         valid_r <= 1'b1;
         cs_n_r <= cs_n_d;
         xram_r <= x_hit;
         yram_r <= y_hit;
         // 25 bits leave the chip: five 32 MB areas, 160 MB in all
         ext_addr_r <= a[AREA_LOG2-1:0]; // R15 R16
         kind_r <= kind_d;
         lane_n_r <= lane_n_d;
         cas_n_r <= cas_n_d;
      end else begin
         valid_r <= 1'b0;
         cs_n_r <= 5'h1F;
         xram_r <= 1'b0;
         yram_r <= 1'b0;
         kind_r <= KIND_NONE;
         lane_n_r <= 4'hF;
         cas_n_r <= 4'hF;
      end
   end

   // Current bus master identifier
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         master_r <= MST_CPU;
      end else if (i_req_valid && !float_active) begin
         master_r <= i_req.master; // R07
      end
   end

   // Refresh request while another master owns the bus
   // The owning master cannot refresh, so the request goes out
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         refresh_request_out_r <= 1'b0;
      end else begin
         refresh_request_out_r <= i_refresh_due & i_bus_released; // R11
      end
   end

   // Output enable of bus and strobe pins
   // Pins are driven again one cycle after the float ends
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         oe_r <= 1'b1;
      end else begin
         oe_r <= ~float_active; // R12
      end
   end

   // Outputs straight from flip-flops
   assign o_reg_rdata = rdata_r;
   assign o_access_valid = valid_r;
   assign o_area_select_n = cs_n_r;
   assign o_xram_select = xram_r;
   assign o_yram_select = yram_r;
   assign o_ext_addr = ext_addr_r;
   assign o_mem_kind = kind_r;
   assign o_lane_mask_write_strobe_n = lane_n_r;
   assign o_lane_column_strobe_n = cas_n_r;
   assign o_bus_master_id = master_r;
   assign o_refresh_request_out = refresh_request_out_r;
   assign o_bus_oe = oe_r;

   // Cache-through bit is dropped from the external address; only the on-chip window match still compares it
   // Both halves reach the same external word, so bit 29 is ignored
   logic unused_through;
   assign unused_through = through;

endmodule
`default_nettype wire
